//--- irc_pkg.sv
// Purpose: Shared constants and types for the image region cropper.
// Assumes: One pixel per stream beat, 32-bit register words on AXI4-Lite.
// Notes:   Offsets are byte addresses, each register one aligned word.
package irc_pkg;

  localparam int DIM_W  = 17;
  localparam int PIX_W  = 16;
  localparam int ADDR_W = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_WIDTH  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_HEIGHT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_HSTART = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_VSTART = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_FWLIM  = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_FHLIM  = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h1C;

  // Control and status bit positions.
  localparam int CTRL_RUN_BIT    = 0;
  localparam int CTRL_HMIR_BIT   = 1;
  localparam int CTRL_VMIR_BIT   = 2;
  localparam int CTRL_ZONE_BIT   = 3;
  localparam int STAT_REJECT_BIT = 0;
  localparam int STAT_RUN_BIT    = 1;
  localparam int STAT_BUSY_BIT   = 2;

  // Reset values.
  localparam logic [DIM_W-1:0] WIDTH_RST  = 17'h00400;
  localparam logic [DIM_W-1:0] HEIGHT_RST = 17'h00400;
  localparam logic [DIM_W-1:0] HSTART_RST = 17'h00000;
  localparam logic [DIM_W-1:0] VSTART_RST = 17'h00000;
  localparam logic [DIM_W-1:0] FWLIM_RST  = 17'h00400;
  localparam logic [DIM_W-1:0] FHLIM_RST  = 17'h00400;

  // Limits of the region and frame settings.
  localparam logic [DIM_W:0] MAX_FRAME_W  = 18'h08000;
  localparam logic [DIM_W:0] MAX_FRAME_H  = 18'h10000;
  localparam logic [DIM_W:0] MIRROR_W_MAX = 18'h05550;
  localparam logic [DIM_W:0] W_MIN        = 18'h00030;
  localparam logic [DIM_W:0] H_MIN        = 18'h00002;
  localparam logic [DIM_W:0] HSTART_MAX   = 18'h07FD0;
  localparam logic [DIM_W:0] VSTART_MAX   = 18'h0FFFF;
  localparam logic [3:0]     H_STEP_BITS  = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {single_zone_layout, two_zone_vertical_layout} irc_zone_t;

  typedef struct packed {
    logic [DIM_W-1:0] width;
    logic [DIM_W-1:0] height;
    logic [DIM_W-1:0] hstart;
    logic [DIM_W-1:0] vstart;
    logic [DIM_W-1:0] fwlim;
    logic [DIM_W-1:0] fhlim;
    logic             hmirror;
    logic             vmirror;
    irc_zone_t        zone_layout;
  } irc_cfg_t;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic             eol;
    logic             eof;
  } irc_pix_t;

endpackage : irc_pkg

//--- irc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the cropper registers.
// Assumes: Register values and error decisions come from the parent.
// Notes:   One write and one read under way at a time.
`timescale 1ns/100ps
module irc_axil_slave (
  input  wire  logic                      aclk,
  input  wire  logic                      aresetn,
  input  wire  logic                      awvalid,
  output logic                            awready,
  input  wire  logic [irc_pkg::ADDR_W-1:0] awaddr,
  input  wire  logic                      wvalid,
  output logic                            wready,
  input  wire  logic [31:0]               wdata,
  input  wire  logic [3:0]                wstrb,
  output logic                            bvalid,
  input  wire  logic                      bready,
  output logic [1:0]                      bresp,
  input  wire  logic                      arvalid,
  output logic                            arready,
  input  wire  logic [irc_pkg::ADDR_W-1:0] araddr,
  output logic                            rvalid,
  input  wire  logic                      rready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            wr_en,
  output logic [irc_pkg::ADDR_W-1:0]      wr_addr,
  output logic [31:0]                     wr_data,
  output logic [3:0]                      wr_strb,
  input  wire  logic                      wr_err,
  output logic [irc_pkg::ADDR_W-1:0]      rd_addr,
  input  wire  logic [31:0]               rd_data,
  input  wire  logic                      rd_err
);
  import irc_pkg::*;

  logic aw_have;
  logic w_have;

  // Address and data are caught separately so either may come first.
  assign awready = !aw_have;
  assign wready  = !w_have;
  assign wr_en   = aw_have && w_have && !bvalid;
  assign rd_addr = araddr;
  assign arready = !rvalid;

  // Write address holding register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_have <= 1'b1;
      wr_addr <= awaddr;
    end else if (wr_en) begin
      aw_have <= 1'b0;
    end
  end

  // Write data holding register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have  <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid && wready) begin
      w_have  <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_en) begin
      w_have <= 1'b0;
    end
  end

  // Write response, which carries a refused write back to software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read data is registered on the same edge that takes the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_err ? 32'h0000_0000 : rd_data;
      rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : irc_axil_slave

//--- irc_limit_check.sv
// Purpose: Checks a candidate region configuration against every limit.
// Assumes: Purely combinational; the parent decides what to do with it.
// Notes:   Memory size for the vertical mirror double buffer is a parameter.
`timescale 1ns/100ps
module irc_limit_check #(
  parameter logic [35:0] MEM_PIXELS = 36'h0_1000_0000
) (
  input  wire  irc_pkg::irc_cfg_t cand,
  output logic                    ok
);
  import irc_pkg::*;

  logic [DIM_W:0]  w, h, hs, vs, fw, fh;
  logic [DIM_W:0]  xsum, ysum, xlim, ylim, wmax, fw_eff;
  logic [35:0]     mem_need;
  logic            fields_ok, sums_ok, mem_ok;

  // Widen everything by one bit so sums cannot wrap.
  assign w  = {1'b0, cand.width};
  assign h  = {1'b0, cand.height};
  assign hs = {1'b0, cand.hstart};
  assign vs = {1'b0, cand.vstart};
  assign fw = {1'b0, cand.fwlim};
  assign fh = {1'b0, cand.fhlim};
  assign xsum = hs + w;
  assign ysum = vs + h;

  // The line store holds shorter lines only when mirroring horizontally.
  assign wmax = cand.hmirror ? MIRROR_W_MAX : MAX_FRAME_W;
  // Without horizontal mirroring the width limit setting is not used.
  assign xlim = cand.hmirror ? fw : MAX_FRAME_W;
  // Height limit is used only for vertical mirroring or two zones.
  assign ylim = (cand.vmirror || cand.zone_layout == two_zone_vertical_layout)
              ? fh : MAX_FRAME_H;

  // Ranges and step sizes of each setting.
  assign fields_ok = (w >= W_MIN) && (w <= wmax) && (w[3:0] == H_STEP_BITS)
                  && (hs <= HSTART_MAX) && (hs[3:0] == H_STEP_BITS)
                  && (h >= H_MIN) && (h <= MAX_FRAME_H)
                  && (vs <= VSTART_MAX)
                  && (fw >= W_MIN) && (fw <= MAX_FRAME_W) && (fw[3:0] == H_STEP_BITS)
                  && (fh >= H_MIN) && (fh <= MAX_FRAME_H);

  assign sums_ok = (xsum <= xlim) && (ysum <= ylim);

  // A vertically mirrored frame must fit twice into external memory.
  assign fw_eff   = cand.hmirror ? fw : xsum;
  assign mem_need = ({18'h00000, fw_eff} * {18'h00000, fh}) << 1;
  assign mem_ok   = !cand.vmirror || (mem_need <= MEM_PIXELS);

  assign ok = fields_ok && sums_ok && mem_ok;

endmodule : irc_limit_check

//--- irc_cropper.sv
// Purpose: Cuts a configurable region out of each camera frame on its way
//          to the host DMA path, with AXI4-Lite configuration registers.
// Assumes: One pixel per beat; eol marks a line's last pixel, eof a frame's.
// Notes:   Rules follow.
// Behaviour
// - Single zone, no vertical mirror: limit ignored.
// - Large enough frames yield exactly the region.
// - Small frames padded to region size.
// - Out-of-limit start or size writes refused, reported.
// - Width, horizontal start in steps of 16.
// - Region settings change only while acquisition stopped.
// - Region size sets and reports output frame size.
// - Horizontal start plus width at most 32768.
// - Vertical start plus height at most 65536.
// - Horizontal mirror: bounded by frame width limit.
// - Vertical mirror: bounded by frame height limit.
// - Vertical mirror: frame must fit external memory.
// - Horizontal mirror caps width at 21840.
// - Width 48 to 32768, step 16, reset 1024.
// - Height and height limit 2..65536, reset 1024.
// - Horizontal start 0 to 32720 step 16.
// - Vertical start 0 to 65535, reset 0.
// - No horizontal mirror: width limit ignored.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module irc_cropper #(
  parameter logic [35:0] MEM_PIXELS = 36'h0_1000_0000
) (
  input  wire  logic                        aclk,
  input  wire  logic                        aresetn,
  input  wire  logic                        s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire  logic [irc_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire  logic                        s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire  logic [31:0]                 s_axi_wdata,
  input  wire  logic [3:0]                  s_axi_wstrb,
  output logic                              s_axi_bvalid,
  input  wire  logic                        s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  input  wire  logic                        s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire  logic [irc_pkg::ADDR_W-1:0]   s_axi_araddr,
  output logic                              s_axi_rvalid,
  input  wire  logic                        s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  input  wire  logic                        s_valid,
  output logic                              s_ready,
  input  wire  irc_pkg::irc_pix_t           s_pix,
  output logic                              m_valid,
  input  wire  logic                        m_ready,
  output irc_pkg::irc_pix_t                 m_pix,
  output logic [irc_pkg::DIM_W-1:0]         frame_width,
  output logic [irc_pkg::DIM_W-1:0]         frame_height
);
  import irc_pkg::*;

  typedef enum logic [1:0] {ST_PASS, ST_PAD_LINE, ST_PAD_FRAME, ST_DROP} irc_state_t;

  irc_cfg_t         cfg;
  irc_cfg_t         cand;
  logic             run;
  logic             reject;
  logic             busy;
  logic             locked;
  logic             wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]      wr_data;
  logic [3:0]       wr_strb;
  logic             wr_err;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]      rd_data;
  logic             rd_err;
  logic [31:0]      cur_word;
  logic [31:0]      merged;
  logic [31:0]      strb_mask;
  logic             cand_ok;
  logic             is_region;
  logic             is_ctrl;
  logic             is_status;
  logic             fits;

  irc_state_t       st;
  logic [DIM_W-1:0] in_x;
  logic [DIM_W-1:0] in_y;
  logic [DIM_W-1:0] out_x;
  logic [DIM_W-1:0] out_y;
  logic             line_done;
  logic             fresh;
  logic             adv;
  logic             take;
  logic             row_ok;
  logic             col_ok;
  logic             emit_pix;
  logic             pad_emit;
  logic             emit;
  logic             last_x;
  logic             last_y;
  logic             out_eof;
  logic             restart;
  logic             pad_need;

  // Bus slave front end.
  irc_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .awaddr  (s_axi_awaddr),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .bresp   (s_axi_bresp),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .araddr  (s_axi_araddr),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  // Limit checker sees the configuration as it would be after the write.
  irc_limit_check #(
    .MEM_PIXELS (MEM_PIXELS)
  ) u_check (
    .cand (cand),
    .ok   (cand_ok)
  );

  // Register image of one address; unmapped addresses read as zero.
  function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      ADDR_CTRL: begin
        v[CTRL_RUN_BIT]  = run;
        v[CTRL_HMIR_BIT] = cfg.hmirror;
        v[CTRL_VMIR_BIT] = cfg.vmirror;
        v[CTRL_ZONE_BIT] = (cfg.zone_layout == two_zone_vertical_layout);
      end
      ADDR_WIDTH:  v[DIM_W-1:0] = cfg.width;
      ADDR_HEIGHT: v[DIM_W-1:0] = cfg.height;
      ADDR_HSTART: v[DIM_W-1:0] = cfg.hstart;
      ADDR_VSTART: v[DIM_W-1:0] = cfg.vstart;
      ADDR_FWLIM:  v[DIM_W-1:0] = cfg.fwlim;
      ADDR_FHLIM:  v[DIM_W-1:0] = cfg.fhlim;
      ADDR_STATUS: begin
        v[STAT_REJECT_BIT] = reject;
        v[STAT_RUN_BIT]    = run;
        v[STAT_BUSY_BIT]   = busy;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_word

  // Address decode shared by reads and writes.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a <= ADDR_STATUS) && (a[1:0] == 2'h0);
  endfunction : mapped

  // Reads inside the function need a process to follow them.
  always_comb begin
    rd_data  = reg_word(rd_addr);
    cur_word = reg_word(wr_addr);
  end
  assign rd_err  = !mapped(rd_addr);

  // Byte lanes merge the write into the current word.
  assign strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign merged    = (cur_word & ~strb_mask) | (wr_data & strb_mask);
  assign is_ctrl   = (wr_addr == ADDR_CTRL);
  assign is_status = (wr_addr == ADDR_STATUS);
  assign is_region = mapped(wr_addr) && !is_ctrl && !is_status;
  assign fits      = (merged[31:DIM_W] == '0);

  // Region settings are frozen while running or while a frame is in flight.
  assign locked = run || busy;

  // Candidate configuration with the written field replaced.
  always_comb begin
    cand = cfg;
    case (wr_addr)
      ADDR_CTRL: begin
        cand.hmirror     = merged[CTRL_HMIR_BIT];
        cand.vmirror     = merged[CTRL_VMIR_BIT];
        cand.zone_layout = merged[CTRL_ZONE_BIT] ? two_zone_vertical_layout
                                                 : single_zone_layout;
      end
      ADDR_WIDTH:  cand.width  = merged[DIM_W-1:0];
      ADDR_HEIGHT: cand.height = merged[DIM_W-1:0];
      ADDR_HSTART: cand.hstart = merged[DIM_W-1:0];
      ADDR_VSTART: cand.vstart = merged[DIM_W-1:0];
      ADDR_FWLIM:  cand.fwlim  = merged[DIM_W-1:0];
      ADDR_FHLIM:  cand.fhlim  = merged[DIM_W-1:0];
      default:     cand = cfg;
    endcase
  end

  // A refused write leaves every register but the reject flag untouched and answers SLVERR.
  // Mode bits written while locked are ignored so that run can still stop.
  assign wr_err = !mapped(wr_addr)
               || (is_region && (locked || !fits || !cand_ok))
               || (is_ctrl && !locked && !cand_ok);

  // Region and mode settings.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.width       <= WIDTH_RST;
      cfg.height      <= HEIGHT_RST;
      cfg.hstart      <= HSTART_RST;
      cfg.vstart      <= VSTART_RST;
      cfg.fwlim       <= FWLIM_RST;
      cfg.fhlim       <= FHLIM_RST;
      cfg.hmirror     <= 1'b0;
      cfg.vmirror     <= 1'b0;
      cfg.zone_layout <= single_zone_layout;
    end else if (wr_en && !wr_err && !locked && (is_region || is_ctrl)) begin
      cfg <= cand;
    end
  end

  // Acquisition run bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= 1'b0;
    end else if (wr_en && !wr_err && is_ctrl) begin
      run <= merged[CTRL_RUN_BIT];
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear in the same write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reject <= 1'b0;
    end else if (wr_en && wr_err) begin
      reject <= 1'b1;
    end else if (wr_en && is_status && merged[STAT_REJECT_BIT]) begin
      reject <= 1'b0;
    end
  end

  // The region size is the DMA frame size reported to the host.
  assign frame_width  = cfg.width;
  assign frame_height = cfg.height;

  // Stream bookkeeping.
  assign adv      = !m_valid || m_ready;
  assign take     = s_valid && s_ready;
  assign row_ok   = (in_y >= cfg.vstart);
  assign col_ok   = (in_x >= cfg.hstart) && !line_done;
  assign emit_pix = take && (st == ST_PASS) && row_ok && col_ok;
  assign pad_emit = ((st == ST_PAD_LINE) || (st == ST_PAD_FRAME)) && adv;
  assign emit     = emit_pix || pad_emit;
  assign last_x   = (out_x == cfg.width - 1'b1);
  assign last_y   = (out_y == cfg.height - 1'b1);
  assign out_eof  = emit && last_x && last_y;
  assign pad_need = row_ok && !line_done && !(emit_pix && last_x);
  assign busy     = !((st == ST_PASS) && fresh) || m_valid;

  // New frames wait for run; a frame already started is always finished.
  assign s_ready = adv && (((st == ST_PASS) && (run || !fresh)) || (st == ST_DROP));

  assign restart = ((st == ST_PASS) && take && s_pix.eof && out_eof)
                || ((st == ST_PAD_FRAME) && out_eof)
                || ((st == ST_DROP) && take && s_pix.eof);

  // Crop sequencer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_PASS;
    end else begin
      case (st)
        ST_PASS: begin
          if (take && s_pix.eof) begin
            st <= out_eof ? ST_PASS : ST_PAD_FRAME;
          end else if (out_eof) begin
            st <= ST_DROP;
          end else if (take && s_pix.eol && pad_need) begin
            st <= ST_PAD_LINE;
          end
        end
        ST_PAD_LINE: begin
          if (pad_emit && last_x) begin
            st <= last_y ? ST_DROP : ST_PASS;
          end
        end
        ST_PAD_FRAME: begin
          if (out_eof) begin
            st <= ST_PASS;
          end
        end
        ST_DROP: begin
          if (take && s_pix.eof) begin
            st <= ST_PASS;
          end
        end
        default: st <= ST_PASS;
      endcase
    end
  end

  // Input position; counter widths cover the largest legal camera frame.
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      in_x <= '0;
      in_y <= '0;
    end else if (take && s_pix.eol) begin
      in_x <= '0;
      in_y <= in_y + 1'b1;
    end else if (take) begin
      in_x <= in_x + 1'b1;
    end
  end

  // Marks that the region line has closed within the current input line.
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      line_done <= 1'b0;
    end else if (take && s_pix.eol) begin
      line_done <= 1'b0;
    end else if (emit_pix && last_x) begin
      line_done <= 1'b1;
    end
  end

  // Frame boundary flag, the only point where settings may change.
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      fresh <= 1'b1;
    end else if (take) begin
      fresh <= 1'b0;
    end
  end

  // Output position within the region.
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      out_x <= '0;
      out_y <= '0;
    end else if (emit && last_x) begin
      out_x <= '0;
      out_y <= out_y + 1'b1;
    end else if (emit) begin
      out_x <= out_x + 1'b1;
    end
  end

  // Output register; padded pixels carry zero as their undefined content.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_valid <= 1'b0;
      m_pix   <= '0;
    end else if (adv) begin
      m_valid <= emit;
      if (emit) begin
        m_pix.data <= emit_pix ? s_pix.data : '0;
        m_pix.eol  <= last_x;
        m_pix.eof  <= last_x && last_y;
      end
    end
  end

endmodule : irc_cropper

//--- irc_camera_model.sv
// Purpose: Camera model that sends frames of a given size.
// Assumes: Pixel data holds row and column in its low bytes.
// Notes:   gap slows it; between beats the data is inverted.
`timescale 1ns/100ps
module irc_camera_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        go,
  input  wire logic        gap,
  input  wire logic [16:0] cw,
  input  wire logic [16:0] ch,
  input  wire logic        ready,
  output logic             valid,
  output irc_pkg::irc_pix_t pix,
  output logic             idle
);
  import irc_pkg::*;
  logic [31:0] n;
  logic [16:0] x, y;
  wire logic lx = x == cw - 17'h00001;
  // Idle data is inverted so that a stale value never passes for a pixel.
  assign pix = '{data: {y[7:0], x[7:0]} ^ {16{!valid}}, eol: lx, eof: n == 32'h1};
  assign idle = n == 32'h0;
  // Each pixel stands until it is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n <= 32'h0;
      valid <= 1'b0;
    end else if (go && idle) begin
      n <= 32'(cw * ch);
      {x, y, valid} <= {34'h0, 1'b1};
    end else if (!valid || ready) begin
      n <= n - {31'h0, valid};
      {x, y} <= valid ? {lx ? 17'h0 : x + 17'h1, y + {16'h0, lx}} : {x, y};
      valid <= n != {31'h0, valid} && !gap;
    end
  end
endmodule : irc_camera_model

//--- irc_cropper_monitor.sv
// Purpose: Port assertions for the region cropper.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound into every cropper instance.
`timescale 1ns/100ps
module irc_cropper_monitor
  import irc_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_valid,
  input wire logic       s_ready,
  input wire logic       m_valid,
  input wire logic       m_ready,
  input wire irc_pix_t   m_pix,
  input wire logic [16:0] frame_width,
  input wire logic [16:0] frame_height
);
  logic [16:0] col;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence stall_s; m_valid && !m_ready; endsequence
  // Column count; a lost or early eol shows up against the width.
  always_ff @(posedge aclk) begin
    if (!aresetn) col <= '0;
    else if (m_valid && m_ready) col <= m_pix.eol ? '0 : col + 17'h00001;
  end
  a_out_hold: assert property (stall_s |=> m_valid && $stable(m_pix)) else $error("hold");
  a_in_block: assert property (stall_s |-> !s_ready) else $error("stall take");
  a_size_frozen: assert property (s_valid && s_ready |=>
    $stable(frame_width) && $stable(frame_height)) else $error("frozen");
  a_eof_eol: assert property (m_valid && m_pix.eof |-> m_pix.eol) else $error("eof");
  a_line_len: assert property (m_valid |-> m_pix.eol == (col == frame_width - 17'h1))
    else $error("line");
  a_width_legal: assert property (frame_width[3:0] == 4'h0 && frame_width >= 17'h30)
    else $error("width");
  a_size_write: assert property ($changed(frame_width) || $changed(frame_height) |->
    ##[0:1] s_axi_bvalid && s_axi_bresp == RESP_OKAY) else $error("size");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("resp");
endmodule : irc_cropper_monitor
bind irc_cropper irc_cropper_monitor mon (.*);

//--- irc_cropper_test.sv
// Purpose: Self-checking bench for the region cropper.
// Assumes: Registers over AXI4-Lite, frames from the camera model.
// Notes:   Output stalls and input gaps are random.
`timescale 1ns/100ps
module irc_cropper_test;
  import irc_pkg::*;
  localparam int RW = 48, RH = 3, HS = 16, VS = 1;
  logic aclk = '0, aresetn = '0, go = '0, gap = '0, m_ready = '0, idle, s_valid, s_ready, m_valid;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h0000A13B;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [16:0] frame_width, frame_height, cw = '0, ch = '0;
  irc_pix_t s_pix, m_pix, q[$];
  int failures = 0, samples_checked = 0, cyc = 0;
  // Writes as address, data and expected response; seven refusals first.
  logic [41:0] wt [17] = '{{ADDR_WIDTH, 32'h28, 2'h2}, {ADDR_WIDTH, 32'h3E8, 2'h2},
    {ADDR_HSTART, 32'h8, 2'h2}, {ADDR_HSTART, 32'h7FD0, 2'h2}, {ADDR_VSTART, 32'hFFFF, 2'h2},
    {ADDR_HEIGHT, 32'h1, 2'h2}, {8'h40, 32'h0, 2'h2}, {ADDR_WIDTH, 32'h30, 2'h0},
    {ADDR_HSTART, 32'h7FD0, 2'h0}, {ADDR_HSTART, 32'h10, 2'h0}, {ADDR_HEIGHT, 32'h3, 2'h0},
    {ADDR_VSTART, 32'hFFFD, 2'h0}, {ADDR_VSTART, 32'h1, 2'h0}, {ADDR_CTRL, 32'h2, 2'h0},
    {ADDR_FWLIM, 32'h30, 2'h2}, {ADDR_CTRL, 32'h1, 2'h0}, {ADDR_WIDTH, 32'h40, 2'h2}};
  irc_cropper dut (.*);
  irc_camera_model cam (.aclk, .aresetn, .go, .gap, .cw, .ch, .ready(s_ready),
    .valid(s_valid), .pix(s_pix), .idle);
  always #5 aclk = ~aclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] a = s ^ (s << 13);
    a = a ^ (a >> 17);
    return a ^ (a << 5);
  endfunction : xs
  task automatic end_of_test();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One bus transfer; the valid releases happen in the clocked block below.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    if (w) {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'h7, a, d};
    else {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
    do @(posedge aclk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
    {s_axi_bready, s_axi_rready} <= 2'h0;
    chk(w ? {32'h0, s_axi_bresp} : {s_axi_rresp, s_axi_rdata}, w ? {32'h0, e} : {e, d});
  endtask : xfer
  task automatic frame(input int w, input int h);
    int x, y;
    for (int r = 0; r < RH; r++) for (int c = 0; c < RW; c++) begin
      x = HS + c;
      y = VS + r;
      q.push_back({x < w && y < h ? {y[7:0], x[7:0]} : 16'h0, c == RW - 1, c + r == RW + RH - 2});
    end
    {cw, ch, go} <= {17'(w), 17'(h), 1'b1};
    @(posedge aclk);
    go <= 1'b0;
    wait (q.size() == 0 && idle);
    @(posedge aclk);
  endtask : frame
  // Random stalls, bus releases once taken, and the hang limit.
  always @(posedge aclk) begin
    seed = xs(seed);
    m_ready <= seed[0] | seed[1];
    gap <= seed[2] & seed[3];
    if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
    if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  // Each delivered pixel is matched against the oldest note.
  always @(posedge aclk) begin
    if (aresetn && m_valid && m_ready) chk(m_pix, q.size() ? q.pop_front() : '1);
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 1; i < 7; i++) xfer(1'b0, 8'(4 * i), i inside {3, 4} ? 32'h0 : 32'h400, 2'h0);
    xfer(1'b0, 8'h44, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 17; i++) xfer(1'b1, wt[i][41:34], wt[i][33:2], wt[i][1:0]);
    chk({frame_width, frame_height}, {17'h30, 17'h3});
    frame(96, 5);
    frame(48, 3);
    xfer(1'b1, ADDR_CTRL, 32'h0, RESP_OKAY);
    xfer(1'b0, ADDR_STATUS, 32'h1, RESP_OKAY);
    end_of_test();
  end
endmodule : irc_cropper_test
